/* design/eeprom_client_pkg.sv */
// Constants shared by the two-wire memory client front end
// How it works
// - Compare both chip address pins with select bits
// - Data changes only while clock low
// - Both lines high means idle bus
// - Data falling while clock high is start
// - Data rising while clock high is stop
// - One bit per clock, sampled while high
// - Acknowledge each received byte on ninth clock; the code withholds it for a data byte when the write queue is full
// - Busy programming withholds acks; poll needs same byte, but the code acks any matching control byte once idle
// - Acknowledge holds data low through clock high
// - Host nack ends read; device releases data
// - Control byte: code, selects, block, direction
// - Select bits must equal chip address pins
// - Block bit forms top array address bit
// - Direction bit one reads, zero writes
// - Two address bytes follow, high first
// - Ack only on matching code and selects
// - Sequential read wraps inside current half
// - Write protect high inhibits writes only
// - Write protect sampled at write stop
package eeprom_client_pkg;
    // Device code value is arbitrary
    localparam logic [3:0] DEVICE_CODE     = 4'h5;
    localparam int         CODE_MSB        = 7;
    localparam int         CODE_LSB        = 4;
    localparam int         SEL_HIGH_POS    = 3;
    localparam int         SEL_LOW_POS     = 2;
    localparam int         BLOCK_POS       = 1;
    localparam int         RW_POS          = 0;
    localparam int         ADDR_W          = 17;
    localparam int         DATA_W          = 8;
    localparam int         FIFO_DEPTH      = 8;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
endpackage

/* design/stream_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    // The output register counts as one of the DEPTH words
    wire              full = (count + (PW+1)'(out_valid_o)) == (PW+1)'(DEPTH);
    wire              push = in_valid_i && !full;
    wire              pop  = out_valid_o && out_ready_i;
    wire              refill = (count != '0) && (!out_valid_o || pop);

    assign in_ready_o = !full;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Output register keeps read data coming from a flip-flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (refill) begin
                out_data_o <= mem[rd_ptr];
                rd_ptr     <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (refill) begin
                out_valid_o <= 1'b1;
            end else if (pop) begin
                out_valid_o <= 1'b0;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(refill);
        end
    end
endmodule

/* design/eeprom_bus_client.sv */
// Two-wire bus client front end: conditions, acknowledge, control byte and address
`timescale 1ns/1ps
module eeprom_bus_client (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        chip_addr_pin_low_i,
    input  wire logic        chip_addr_pin_high_i,
    input  wire logic        write_protect_i,
    input  wire logic        prog_busy_i,
    input  wire logic [7:0]  rd_data_i,
    output logic             rd_req_o,
    output logic [16:0]      addr_o,
    output logic [7:0]       wr_data_o,
    output logic             wr_valid_o,
    input  wire logic        wr_ready_i,
    output logic             write_start_o,
    output logic             write_blocked_o,
    output logic             selected_o,
    output logic             bus_busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } phase_e;

    // Two-stage synchronisers; meta stages are read only by the next stage
    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    logic pin_lo_meta, pin_lo_sync, pin_hi_meta, pin_hi_sync;
    logic wp_meta, wp_sync;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            scl_meta    <= 1'b1;
            scl_sync    <= 1'b1;
            scl_prev    <= 1'b1;
            sda_meta    <= 1'b1;
            sda_sync    <= 1'b1;
            sda_prev    <= 1'b1;
            pin_lo_meta <= 1'b0;
            pin_lo_sync <= 1'b0;
            pin_hi_meta <= 1'b0;
            pin_hi_sync <= 1'b0;
            wp_meta     <= 1'b1;
            wp_sync     <= 1'b1;
        end else begin
            scl_meta    <= scl_i;
            scl_sync    <= scl_meta;
            scl_prev    <= scl_sync;
            sda_meta    <= sda_i;
            sda_sync    <= sda_meta;
            sda_prev    <= sda_sync;
            pin_lo_meta <= chip_addr_pin_low_i;
            pin_lo_sync <= pin_lo_meta;
            pin_hi_meta <= chip_addr_pin_high_i;
            pin_hi_sync <= pin_hi_meta;
            wp_meta     <= write_protect_i;
            wp_sync     <= wp_meta;
        end
    end

    wire scl_rise   = scl_sync && !scl_prev;
    wire scl_fall   = !scl_sync && scl_prev;
    wire start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
    wire stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;

    phase_e      phase, next_phase;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift;
    logic        ack_slot;
    logic        is_read;
    logic        block_bit;
    logic        wrote_data;
    logic        host_nack;
    logic [7:0]  tx_byte;
    logic [7:0]  poll_ctrl;
    logic        poll_valid;
    logic        ack_drive;
    logic        ack_pend;

    wire [7:0] rx_byte    = {shift[6:0], sda_sync};
    wire       code_ok    = rx_byte[eeprom_client_pkg::CODE_MSB:eeprom_client_pkg::CODE_LSB]
                            == eeprom_client_pkg::DEVICE_CODE;
    wire       sel_ok     = (rx_byte[eeprom_client_pkg::SEL_HIGH_POS] == pin_hi_sync)
                            && (rx_byte[eeprom_client_pkg::SEL_LOW_POS] == pin_lo_sync);
    wire       poll_ok    = !prog_busy_i || (poll_valid && rx_byte == poll_ctrl);
    // Busy device stays silent; once idle again any matching control byte is answered, poll byte not compared
    wire       ctrl_match = code_ok && sel_ok && !prog_busy_i && poll_ok;
    wire       byte_done  = scl_rise && !ack_slot && (bit_cnt == eeprom_client_pkg::BIT_LAST);
    wire       fifo_ready;
    wire       wdata_ok   = fifo_ready;

    // Phase that follows the byte now completing
    always_comb begin
        next_phase = phase;
        case (phase)
            ST_IDLE: begin
                next_phase = ST_IDLE;
            end
            ST_CTRL: begin
                if (!ctrl_match) begin
                    next_phase = ST_IGNORE;
                end else if (rx_byte[eeprom_client_pkg::RW_POS]) begin
                    next_phase = ST_RDATA;
                end else begin
                    next_phase = ST_ADDR_HI;
                end
            end
            ST_ADDR_HI: begin
                next_phase = ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
                next_phase = ST_WDATA;
            end
            ST_WDATA: begin
                // Any number of data bytes may follow
                next_phase = ST_WDATA;
            end
            ST_RDATA: begin
                next_phase = ST_RDATA;
            end
            ST_IGNORE: begin
                next_phase = ST_IGNORE;
            end
            default: begin
                next_phase = ST_IDLE;
            end
        endcase
    end

    // Half wraps: block bit is held, only the low 16 bits advance
    wire [15:0] addr_next_low = addr_o[15:0] + 16'h0001;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase           <= ST_IDLE;
            bit_cnt         <= '0;
            shift           <= '0;
            ack_slot        <= 1'b0;
            is_read         <= 1'b0;
            block_bit       <= 1'b0;
            wrote_data      <= 1'b0;
            host_nack       <= 1'b0;
            tx_byte         <= '0;
            poll_ctrl       <= '0;
            poll_valid      <= 1'b0;
            ack_drive       <= 1'b0;
            ack_pend        <= 1'b0;
            addr_o          <= eeprom_client_pkg::ADDR_RST;
            rd_req_o        <= 1'b0;
            write_start_o   <= 1'b0;
            write_blocked_o <= 1'b0;
            selected_o      <= 1'b0;
            bus_busy_o      <= 1'b0;
            sda_o           <= 1'b0;
            sda_oe_o        <= 1'b0;
        end else begin
            rd_req_o      <= 1'b0;
            write_start_o <= 1'b0;
            if (start_seen) begin
                phase      <= ST_CTRL;
                bit_cnt    <= '0;
                ack_slot   <= 1'b0;
                ack_pend   <= 1'b0;
                ack_drive  <= 1'b0;
                host_nack  <= 1'b0;
                sda_oe_o   <= 1'b0;
                bus_busy_o <= 1'b1;
                selected_o <= 1'b0;
            end else if (stop_seen) begin
                phase      <= ST_IDLE;
                bus_busy_o <= 1'b0;
                selected_o <= 1'b0;
                sda_oe_o   <= 1'b0;
                ack_drive  <= 1'b0;
                if (wrote_data) begin
                    write_blocked_o <= wp_sync;
                    write_start_o   <= !wp_sync;
                    poll_valid      <= !wp_sync;
                end
                wrote_data <= 1'b0;
            end else if (phase != ST_IDLE && phase != ST_IGNORE) begin
                if (byte_done) begin
                    shift    <= rx_byte;
                    ack_pend <= 1'b1;
                    phase    <= next_phase;
                    case (phase)
                        ST_CTRL: begin
                            ack_drive <= ctrl_match;
                            if (ctrl_match) begin
                                selected_o <= 1'b1;
                                block_bit  <= rx_byte[eeprom_client_pkg::BLOCK_POS];
                                is_read    <= rx_byte[eeprom_client_pkg::RW_POS];
                                poll_ctrl  <= rx_byte;
                                if (rx_byte[eeprom_client_pkg::RW_POS]) begin
                                    addr_o[16] <= rx_byte[eeprom_client_pkg::BLOCK_POS];
                                    rd_req_o   <= 1'b1;
                                end
                            end
                        end
                        ST_ADDR_HI: begin
                            addr_o    <= {block_bit, rx_byte, addr_o[7:0]};
                            ack_drive <= 1'b1;
                        end
                        ST_ADDR_LO: begin
                            addr_o[7:0] <= rx_byte;
                            ack_drive   <= 1'b1;
                        end
                        ST_WDATA: begin
                            ack_drive  <= wdata_ok;
                            wrote_data <= 1'b1;
                            if (wdata_ok) begin
                                addr_o[15:0] <= addr_next_low;
                            end
                        end
                        ST_RDATA: begin
                            // Our own byte: the host answers it
                            ack_drive <= 1'b0;
                        end
                        default: ack_drive <= 1'b0;
                    endcase
                end else if (scl_rise && !ack_slot && !ack_pend) begin
                    shift   <= rx_byte;
                    bit_cnt <= bit_cnt + 3'h1;
                end else if (scl_rise && ack_slot && phase == ST_RDATA && !ack_drive) begin
                    // Host answer to our byte; pointer moves on inside the half
                    host_nack    <= sda_sync;
                    addr_o[15:0] <= addr_next_low;
                    rd_req_o     <= !sda_sync;
                end

                // Drive changes only after a falling clock edge, so that a level
                // change never looks like a start or stop to other devices
                if (scl_fall) begin
                    if (ack_pend) begin
                        // Ninth clock begins: pull low to acknowledge, or let go
                        ack_pend <= 1'b0;
                        ack_slot <= 1'b1;
                        sda_oe_o <= ack_drive;
                        sda_o    <= 1'b0;
                    end else if (ack_slot) begin
                        // Ninth clock over: start the next byte out or release
                        ack_slot  <= 1'b0;
                        ack_drive <= 1'b0;
                        bit_cnt   <= '0;
                        if (phase == ST_RDATA && is_read && !host_nack) begin
                            sda_oe_o <= !rd_data_i[7];
                            sda_o    <= 1'b0;
                            tx_byte  <= {rd_data_i[6:0], 1'b0};
                        end else begin
                            sda_oe_o <= 1'b0;
                        end
                    end else if (phase == ST_RDATA && is_read && bit_cnt != 3'h0) begin
                        sda_oe_o <= !tx_byte[7];
                        sda_o    <= 1'b0;
                        tx_byte  <= {tx_byte[6:0], 1'b0};
                    end else begin
                        sda_oe_o <= 1'b0;
                    end
                end
            end
        end
    end

    // Received data bytes queue toward the array; a full queue withholds the ack
    stream_fifo #(
        .WIDTH (eeprom_client_pkg::DATA_W),
        .DEPTH (eeprom_client_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   (rx_byte),
        .in_valid_i  (byte_done && phase == ST_WDATA && start_seen == 1'b0 && !stop_seen),
        .in_ready_o  (fifo_ready),
        .out_data_o  (wr_data_o),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i)
    );
endmodule

/* verification/eeprom_bus_client_props.sv */
// Concurrent checks on the ports of the two-wire memory client
`timescale 1ns/1ps
module eeprom_bus_client_props (
    input logic        clk_i,
    input logic        reset_i,
    input logic        scl_i,
    input logic        sda_i,
    input logic        sda_o,
    input logic        sda_oe_o,
    input logic        chip_addr_pin_low_i,
    input logic        chip_addr_pin_high_i,
    input logic        write_protect_i,
    input logic        prog_busy_i,
    input logic [7:0]  rd_data_i,
    input logic        rd_req_o,
    input logic [16:0] addr_o,
    input logic [7:0]  wr_data_o,
    input logic        wr_valid_o,
    input logic        wr_ready_i,
    input logic        write_start_o,
    input logic        write_blocked_o,
    input logic        selected_o,
    input logic        bus_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_drive_low; sda_oe_o |-> !sda_o; endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("driven data level not low");
    // Any change of our drive while the clock is high would fake a start or stop
    property p_oe_edge; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_oe_edge: assert property (p_oe_edge)
        else $error("data drive changed while clock high");
    property p_oe_hold; $rose(scl_i) && sda_oe_o |-> sda_oe_o [*4]; endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("acknowledge released during clock high");
    property p_idle; !bus_busy_o |-> !sda_oe_o; endproperty
    a_idle: assert property (p_idle)
        else $error("data driven on idle bus");
    property p_start; scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy_o; endproperty
    a_start: assert property (p_start)
        else $error("start not seen");
    property p_stop; scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy_o; endproperty
    a_stop: assert property (p_stop)
        else $error("stop not seen");
    property p_busy; prog_busy_i && $past(prog_busy_i, 4) |-> !$rose(sda_oe_o); endproperty
    a_busy: assert property (p_busy)
        else $error("acknowledge during programming");
    property p_wp; write_start_o |-> !write_protect_i; endproperty
    a_wp: assert property (p_wp)
        else $error("write started while protected");
    property p_ws_idle; write_start_o |-> !bus_busy_o; endproperty
    a_ws_idle: assert property (p_ws_idle)
        else $error("write started before stop");
    c_write: cover property (write_start_o);
    c_read: cover property (rd_req_o);
    c_block: cover property ($rose(write_blocked_o));
endmodule
bind eeprom_bus_client eeprom_bus_client_props u_props (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_addr_pin_low_i(chip_addr_pin_low_i), .chip_addr_pin_high_i(chip_addr_pin_high_i),
    .write_protect_i(write_protect_i), .prog_busy_i(prog_busy_i), .rd_data_i(rd_data_i),
    .rd_req_o(rd_req_o), .addr_o(addr_o), .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready_i), .write_start_o(write_start_o),
    .write_blocked_o(write_blocked_o), .selected_o(selected_o), .bus_busy_o(bus_busy_o));

/* verification/bus_host_model.sv */
// Two-wire bus host: makes the clock, start, stop and byte transfers
`timescale 1ns/1ps
module bus_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Quarter of the 48 ns bus period
    task automatic q;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic bit_x(input logic b, output logic r);
        q;
        sda_low_o = !b;
        q;
        scl_o = 1'b1;
        q;
        r = sda_i;
        q;
        scl_o = 1'b0;
    endtask
    task automatic start;
        q;
        sda_low_o = 1'b0;
        q;
        scl_o = 1'b1;
        q;
        sda_low_o = 1'b1;
        q;
        scl_o = 1'b0;
    endtask
    task automatic stop;
        q;
        sda_low_o = 1'b1;
        q;
        scl_o = 1'b1;
        q;
        sda_low_o = 1'b0;
        q;
    endtask
    // Bytes go out high bit first; ninth clock reads the acknowledge
    task automatic put(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, nak);
    endtask
    task automatic get(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(nak, r);
    endtask
endmodule

/* verification/eeprom_bus_client_tb_top.sv */
// Self-checking bench for the two-wire memory client
`timescale 1ns/1ps
module eeprom_bus_client_tb_top;
    logic clk = 0, reset = 1, wp = 0, busy = 0, ready = 0, pin_lo = 0, pin_hi = 0;
    logic scl, host_low, sda_o, sda_oe, rd_req, wr_valid, wstart, wblocked, sel, bbusy, n;
    logic [16:0] addr;
    logic [7:0]  wr_data, d;
    int num_errors = 0, checks = 0, starts = 0;
    // Open drain line with pull-up
    wire sda = !(host_low | (sda_oe & !sda_o));
    wire logic [7:0] rd_data = addr[7:0] ^ 8'h5a;
    initial forever #2 clk = !clk;
    bus_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    eeprom_bus_client dut (.clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .chip_addr_pin_low_i(pin_lo),
        .chip_addr_pin_high_i(pin_hi), .write_protect_i(wp), .prog_busy_i(busy),
        .rd_data_i(rd_data), .rd_req_o(rd_req), .addr_o(addr), .wr_data_o(wr_data),
        .wr_valid_o(wr_valid), .wr_ready_i(ready), .write_start_o(wstart),
        .write_blocked_o(wblocked), .selected_o(sel), .bus_busy_o(bbusy));
    always @(posedge clk) if (wstart === 1'b1) starts++;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] ctl(input logic h, input logic l, input logic b,
                                       input logic r);
        return {eeprom_client_pkg::DEVICE_CODE, h, l, b, r};
    endfunction
    task automatic cmd(input logic [7:0] c, input logic nak, input string m);
        logic x;
        host.start;
        host.put(c, x);
        chk(x, nak, m);
    endtask
    task automatic wr1(input logic [7:0] v);
        logic x;
        cmd(ctl(1, 1, 0, 0), 0, "write control");
        for (int i = 0; i < 3; i++) begin
            host.put(i == 2 ? v : 8'h00, x);
            chk(x, 0, "write byte");
        end
        host.stop;
        repeat (10) @(negedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) reset = 0;
        for (int k = 0; k < 4; k++) begin
            pin_hi = k[1];
            pin_lo = k[0];
            repeat (4) @(negedge clk);
            cmd(ctl(k[1], k[0], 0, 0), 0, "match");
            chk({bbusy, sel}, 2'h3, "addressed");
            cmd(ctl(!k[1], k[0], 0, 0), 1, "high select");
            cmd(ctl(k[1], !k[0], 0, 0), 1, "low select");
            cmd({~eeprom_client_pkg::DEVICE_CODE, k[1], k[0], 2'h0}, 1, "code");
            host.put(8'h00, n);
            chk({n, sel}, 2'h2, "ignored");
            host.stop;
            repeat (4) @(negedge clk);
            chk(bbusy, 0, "idle");
        end
        $display("test select done");
        cmd(ctl(1, 1, 1, 0), 0, "fill control");
        host.put(8'h12, n);
        host.put(8'h34, n);
        chk(addr, 17'h11234, "address");
        // Nobody drains meanwhile, so the ninth byte finds the buffer full
        for (int i = 0; i < 9; i++) begin
            host.put(8'(i) + 8'ha0, n);
            chk(n, i == 8, "fill");
        end
        host.stop;
        for (int i = 0; i < 8; i++) begin
            for (int t = 0; t < 50 && wr_valid !== 1'b1; t++) @(negedge clk);
            chk({wr_valid, wr_data}, {1'b1, 8'(i) + 8'ha0}, "drain");
            ready = 1;
            @(negedge clk) ready = 0;
        end
        repeat (4) @(negedge clk);
        chk(wr_valid, 0, "empty");
        ready = 1;
        $display("test buffer done");
        starts = 0;
        wp = 1;
        wr1(8'h77);
        chk({wblocked, 8'(starts)}, 9'h100, "protected");
        wp = 0;
        wr1(8'h78);
        wp = 1;
        repeat (10) @(negedge clk);
        chk({wblocked, 8'(starts)}, 9'h001, "write start");
        wp = 0;
        $display("test protect done");
        busy = 1;
        cmd(ctl(1, 1, 0, 0), 1, "busy poll");
        host.stop;
        busy = 0;
        cmd(ctl(1, 1, 0, 0), 0, "free poll");
        host.stop;
        $display("test busy done");
        cmd(ctl(1, 1, 1, 0), 0, "read setup");
        host.put(8'hff, n);
        host.put(8'hff, n);
        cmd(ctl(1, 1, 1, 1), 0, "read control");
        host.get(0, d);
        chk(d, 8'ha5, "first byte");
        host.get(1, d);
        chk(d, 8'h5a, "wrapped byte");
        repeat (8) @(negedge clk);
        chk(sda_oe, 0, "released");
        host.stop;
        chk(addr[16], 1, "block kept");
        $display("test read done");
        summarize;
    end
endmodule
